// ### ods_serial_load.sv
// Serial load logic of an eight channel 12-bit converter
// How it works
// - Sample data on each serial clock fall
// - Shift only while frame sync held low
// - Sixteenth fall loads addressed input latch; here via the word buffer, held while CTRL hold is set, dropped on overrun
// - Sixteen bits, code MSB arrives first
// - Code, address bit, three select bits follow
// - Address mismatch discards word, no latch load
// - Mismatched words still pass out serially
// - Serial output presents shift register output
// - Load strobe copies all input latches
// - Clear strobe zeroes all output latches
// - After sixteen bits, wait for frame fall
// - Output changes on following serial clock rise
// - Select value 0 to 7 picks channel
// - Clear leaves input latches untouched
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
module ods_serial_load
	import ods_pkg::*;
(
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          reset_n,
	// Serial link pins
	input  wire logic          frame_sync_n,
	input  wire logic          serial_clock_in,
	input  wire logic          serial_data_in,
	output logic               serial_data_out,
	// Strap and strobes
	input  wire logic          device_address_pin,
	input  wire logic          load_all_n,
	input  wire logic          clear_outputs_n,
	// Output latch codes, channel 0 in the low bits
	output logic [95:0]        dac_codes,
	// Avalon-MM slave
	input  wire logic [7:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_writedata,
	output logic [31:0]        avs_readdata,
	output logic               avs_waitrequest
);

	typedef struct packed {
		logic [SYNC_W-1:0]                       meta;
		logic [SYNC_W-1:0]                       sync;
		logic                                    sclk_prev;
		logic                                    fs_prev;
		logic [WORD_BITS-1:0]                    shift;
		logic [4:0]                              bit_cnt;
		logic                                    sdo;
		logic                                    pend_v;
		logic [PEND_BITS-1:0]                    pend;
		logic [CHAN_COUNT-1:0][CODE_BITS-1:0]    in_lat;
		logic [CHAN_COUNT-1:0][CODE_BITS-1:0]    out_lat;
		logic                                    hold;
		logic                                    overrun;
		logic [15:0]                             acc_cnt;
		logic [15:0]                             disc_cnt;
		logic                                    ack;
		logic [31:0]                             rdata;
	} ods_state_t;

	localparam ods_state_t STATE_RESET = '{
		meta:      '1,
		sync:      '1,
		sclk_prev: 1'b1,
		fs_prev:   1'b1,
		shift:     '0,
		bit_cnt:   FULL_CNT,
		sdo:       1'b0,
		pend_v:    1'b0,
		pend:      '0,
		in_lat:    {CHAN_COUNT{CODE_RESET}},
		out_lat:   {CHAN_COUNT{CODE_RESET}},
		hold:      HOLD_RESET,
		overrun:   1'b0,
		acc_cnt:   CNT_RESET,
		disc_cnt:  CNT_RESET,
		ack:       1'b0,
		rdata:     DATA_RESET
	};

	// Saturating event counter step
	function automatic logic [15:0] bump(input logic [15:0] cnt);
		bump = (cnt == 16'hffff) ? cnt : cnt + 16'h0001;
	endfunction

	// Register word index inside a block of eight
	function automatic logic [2:0] lane(input logic [7:0] addr);
		lane = addr[4:2];
	endfunction

	ods_state_t              s_q;
	ods_state_t              s_d;

	// Buffer between capture and the input latches
	logic                    fifo_in_ready;
	logic                    fifo_out_valid;
	logic                    fifo_out_ready;
	logic [PEND_BITS-1:0]    fifo_out_data;
	logic [FIFO_LVL_W-1:0]   fifo_level;

	// Synchronised pin levels and edges
	logic                    sclk_s;
	logic                    fs_s;
	logic                    sdi_s;
	logic                    addr_s;
	logic                    load_s;
	logic                    clr_s;
	logic                    sclk_fall;
	logic                    sclk_rise;
	logic                    fs_fall;
	logic                    bus_req;
	logic                    bus_wr;
	logic                    push;

	assign sclk_s    = s_q.sync[SYNC_SCLK];
	assign fs_s      = s_q.sync[SYNC_FS];
	assign sdi_s     = s_q.sync[SYNC_SDI];
	assign addr_s    = s_q.sync[SYNC_ADDR];
	assign load_s    = s_q.sync[SYNC_LOAD];
	assign clr_s     = s_q.sync[SYNC_CLR];
	assign sclk_fall = s_q.sclk_prev & ~sclk_s;
	assign sclk_rise = ~s_q.sclk_prev & sclk_s;
	assign fs_fall   = s_q.fs_prev & ~fs_s;

	assign bus_req         = avs_read | avs_write;
	assign bus_wr          = avs_write & s_q.ack;
	assign avs_waitrequest = bus_req & ~s_q.ack;
	assign avs_readdata    = s_q.rdata;
	assign serial_data_out = s_q.sdo;
	assign dac_codes       = s_q.out_lat;
	assign push            = s_q.pend_v & fifo_in_ready;
	assign fifo_out_ready  = ~s_q.hold;

	ods_fifo #(
		.WIDTH (PEND_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.in_valid  (s_q.pend_v),
		.in_ready  (fifo_in_ready),
		.in_data   (s_q.pend),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	always_comb
	begin
		logic [4:0]           cnt;
		logic [WORD_BITS-1:0] word;
		logic [2:0]           sel;
		s_d  = s_q;
		cnt  = s_q.bit_cnt;
		word = '0;
		sel  = '0;

		// Pins pass two flip-flops before use
		s_d.meta      = {clear_outputs_n, load_all_n, device_address_pin,
		                 serial_data_in, frame_sync_n, serial_clock_in};
		s_d.sync      = s_q.meta;
		s_d.sclk_prev = sclk_s;
		s_d.fs_prev   = fs_s;

		// One wait state, then the answer
		s_d.ack = bus_req & ~s_q.ack;

		// Register writes
		if (bus_wr)
		begin
			case (avs_address)
				REG_CTRL:
					s_d.hold = avs_writedata[CTRL_HOLD_POS];
				REG_STATUS:
					if (avs_writedata[STAT_OVERRUN_POS])
						s_d.overrun = 1'b0;
				default:
					s_d.hold = s_q.hold;
			endcase
		end

		// Pending word moves into the buffer
		if (push)
			s_d.pend_v = 1'b0;

		// Frame fall rearms the shifter
		if (fs_fall)
			cnt = '0;

		// Serial capture
		if (sclk_fall && !fs_s && cnt != FULL_CNT)
		begin
			word        = {s_q.shift[WORD_BITS-2:0], sdi_s};
			s_d.shift   = word;
			s_d.bit_cnt = cnt + 5'h01;
			if (cnt == LAST_BIT_CNT)
			begin
				if (word[ADDR_BIT_POS] == addr_s)
				begin
					if (s_d.pend_v)
						s_d.overrun = 1'b1;
					else
					begin
						s_d.pend   = {word[SEL_MSB_POS:0], word[CODE_MSB_POS:CODE_LSB_POS]};
						s_d.pend_v = 1'b1;
					end
					s_d.acc_cnt = bump(s_q.acc_cnt);
				end
				else
					s_d.disc_cnt = bump(s_q.disc_cnt);
			end
		end
		else
			s_d.bit_cnt = cnt;

		// Shifted data leaves on the rise whether accepted or not
		if (sclk_rise)
			s_d.sdo = s_q.shift[WORD_BITS-1];

		// Buffered word lands in its input latch
		if (fifo_out_valid && fifo_out_ready)
		begin
			sel                = fifo_out_data[PEND_BITS-1:CODE_BITS];
			s_d.in_lat[sel]    = fifo_out_data[CODE_BITS-1:0];
		end

		// Output latch strobes
		if (!clr_s)
			s_d.out_lat = {CHAN_COUNT{CODE_RESET}};
		else if (!load_s)
			s_d.out_lat = s_q.in_lat;

		// Read data for the answering cycle
		s_d.rdata = DATA_RESET;
		if (avs_read && !s_q.ack)
		begin
			if (avs_address == REG_CTRL)
				s_d.rdata[CTRL_HOLD_POS] = s_q.hold;
			else if (avs_address == REG_STATUS)
			begin
				s_d.rdata[STAT_FRAME_POS]                         = ~fs_s;
				s_d.rdata[STAT_OVERRUN_POS]                       = s_q.overrun;
				s_d.rdata[STAT_PEND_POS]                          = s_q.pend_v;
				s_d.rdata[STAT_LEVEL_LSB+FIFO_LVL_W-1:STAT_LEVEL_LSB] = fifo_level;
			end
			else if (avs_address == REG_ACCEPTED)
				s_d.rdata[15:0] = s_q.acc_cnt;
			else if (avs_address == REG_DISCARD)
				s_d.rdata[15:0] = s_q.disc_cnt;
			else if (avs_address[7:5] == REG_IN_BASE[7:5] && avs_address[1:0] == 2'h0)
				s_d.rdata[CODE_BITS-1:0] = s_q.in_lat[lane(avs_address)];
			else if (avs_address[7:5] == REG_OUT_BASE[7:5] && avs_address[1:0] == 2'h0)
				s_d.rdata[CODE_BITS-1:0] = s_q.out_lat[lane(avs_address)];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			s_q <= STATE_RESET;
		else
			s_q <= s_d;
	end

endmodule

// ### ods_pkg.sv
// Constants for the octal converter serial load block
package ods_pkg;

	// Serial word layout
	localparam int WORD_BITS     = 16;
	localparam int CODE_BITS     = 12;
	localparam int CHAN_COUNT    = 8;
	localparam int SEL_BITS      = 3;
	localparam int CODE_MSB_POS  = 15;
	localparam int CODE_LSB_POS  = 4;
	localparam int ADDR_BIT_POS  = 3;
	localparam int SEL_MSB_POS   = 2;
	localparam int PEND_BITS     = SEL_BITS + CODE_BITS;
	localparam logic [4:0] LAST_BIT_CNT = 5'h0f;
	localparam logic [4:0] FULL_CNT     = 5'h10;

	// Word buffer between capture and input latches
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_LVL_W = 4;

	// Pin synchroniser lanes
	localparam int SYNC_W    = 6;
	localparam int SYNC_SCLK = 0;
	localparam int SYNC_FS   = 1;
	localparam int SYNC_SDI  = 2;
	localparam int SYNC_ADDR = 3;
	localparam int SYNC_LOAD = 4;
	localparam int SYNC_CLR  = 5;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_ACCEPTED = 8'h08;
	localparam logic [7:0] REG_DISCARD  = 8'h0c;
	localparam logic [7:0] REG_IN_BASE  = 8'h20;
	localparam logic [7:0] REG_OUT_BASE = 8'h40;

	// Register fields
	localparam int CTRL_HOLD_POS     = 0;
	localparam int STAT_FRAME_POS    = 0;
	localparam int STAT_OVERRUN_POS  = 1;
	localparam int STAT_PEND_POS     = 2;
	localparam int STAT_LEVEL_LSB    = 4;

	// Values after reset
	localparam logic        HOLD_RESET  = 1'b0;
	localparam logic [11:0] CODE_RESET  = 12'h000;
	localparam logic [15:0] CNT_RESET   = 16'h0000;
	localparam logic [31:0] DATA_RESET  = 32'h0000_0000;

endpackage

// ### ods_fifo.sv
// Word buffer with valid and ready on both sides
`timescale 1ns/1ns
module ods_fifo
	import ods_pkg::*;
#(
	parameter int WIDTH = PEND_BITS,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               reset_n,
	// Filling side
	input  wire logic               in_valid,
	output logic                    in_ready,
	input  wire logic [WIDTH-1:0]   in_data,
	// Draining side
	output logic                    out_valid,
	input  wire logic               out_ready,
	output logic [WIDTH-1:0]        out_data,
	// Fill level
	output logic [FIFO_LVL_W-1:0]   level
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [2:0]                  wr_ptr;
		logic [2:0]                  rd_ptr;
		logic [FIFO_LVL_W-1:0]       count;
	} ods_fifo_state_t;

	ods_fifo_state_t s_q;
	ods_fifo_state_t s_d;
	logic            push;
	logic            pop;

	// Honest full and empty from the count
	assign in_ready  = (s_q.count != FIFO_LVL_W'(DEPTH));
	assign out_valid = (s_q.count != '0);
	assign out_data  = s_q.mem[s_q.rd_ptr];
	assign level     = s_q.count;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wr_ptr] = in_data;
			s_d.wr_ptr          = s_q.wr_ptr + 3'h1;
		end
		if (pop)
			s_d.rd_ptr = s_q.rd_ptr + 3'h1;
		if (push && !pop)
			s_d.count = s_q.count + 4'h1;
		else if (pop && !push)
			s_d.count = s_q.count - 4'h1;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule

// ### ods_serial_load_sva.sv
// Port checks for the serial load block
`timescale 1ns/1ns
module ods_serial_load_sva
	import ods_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset_n,
	// Link and strobes
	input wire logic        serial_clock_in,
	input wire logic        serial_data_out,
	input wire logic        load_all_n,
	input wire logic        clear_outputs_n,
	input wire logic [95:0] dac_codes,
	// Bus
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_req_new;
		$rose(avs_read || avs_write);
	endsequence
	sequence s_clr_held;
		!clear_outputs_n [*4];
	endsequence
	sequence s_rd_ack;
		avs_read && !avs_waitrequest;
	endsequence
	a_clear_zero: assert property (s_clr_held |=> dac_codes == '0)
		else $error("outputs not zero under clear");
	a_clear_wins: assert property ((!clear_outputs_n && !load_all_n) [*4] |=> dac_codes == '0)
		else $error("load beat clear");
	a_codes_steady: assert property ((load_all_n && clear_outputs_n) [*5] |=> $stable(dac_codes))
		else $error("outputs moved without strobe");
	a_sdo_steady: assert property ($stable(serial_clock_in) [*8] |=> $stable(serial_data_out))
		else $error("serial out moved without clock rise");
	a_wait_first: assert property (s_req_new |-> avs_waitrequest)
		else $error("no wait on new request");
	a_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read answer late");
	a_idle_nowait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("wait without request");
	a_hole_zero: assert property (s_rd_ack ##0 avs_address == 8'h10 |-> avs_readdata == '0)
		else $error("unmapped read not zero");
	a_out_readback: assert property (s_rd_ack ##0 avs_address == REG_OUT_BASE && $stable(dac_codes)
		|-> avs_readdata == {20'h0_0000, dac_codes[11:0]})
		else $error("output latch readback wrong");
endmodule
bind ods_serial_load ods_serial_load_sva chk_u
(
	.sys_clk(sys_clk), .reset_n(reset_n), .serial_clock_in(serial_clock_in),
	.serial_data_out(serial_data_out), .load_all_n(load_all_n), .clear_outputs_n(clear_outputs_n),
	.dac_codes(dac_codes), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);

// ### ods_host_model.sv
// Host controller that frames serial words
`timescale 1ns/1ns
module ods_host_model
(
	// Clock
	input  wire logic sys_clk,
	// Serial link
	output logic      frame_sync_n,
	output logic      serial_clock_in,
	output logic      serial_data_in,
	input  wire logic serial_data_out
);
	logic [15:0] echo_q;
	initial
	begin
		frame_sync_n = 1'b1;
		serial_clock_in = 1'b1;
		serial_data_in = 1'b0;
		echo_q = 16'h0000;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Word MSB first, then extra clocks; serial out caught at each word bit fall, not at extra clock falls
	task automatic send(input logic [15:0] w, input int extra);
		frame_sync_n <= 1'b0;
		cyc(4);
		for (int i = 15; i >= -extra; i--)
		begin
			serial_data_in <= (i >= 0) ? w[i] : 1'b1;
			cyc(4);
			serial_clock_in <= 1'b0;
			@(negedge sys_clk);
			if (i >= 0)
				echo_q[i] = serial_data_out;
			cyc(4);
			serial_clock_in <= 1'b1;
		end
		cyc(4);
		frame_sync_n <= 1'b1;
		serial_data_in <= ~serial_data_in;
		cyc(8);
	endtask
endmodule

// ### test_ods_serial_load.sv
// Self-checking bench for the serial load block
`timescale 1ns/1ns
module test_ods_serial_load
	import ods_pkg::*;
;
	logic        sys_clk, reset_n, frame_sync_n, serial_clock_in, serial_data_in, serial_data_out;
	logic        device_address_pin, load_all_n, clear_outputs_n, avs_read, avs_write, avs_waitrequest;
	logic [95:0] dac_codes;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	int          mismatches, checks;
	ods_serial_load dut_u
	(
		.sys_clk(sys_clk), .reset_n(reset_n), .frame_sync_n(frame_sync_n),
		.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.device_address_pin(device_address_pin), .load_all_n(load_all_n), .clear_outputs_n(clear_outputs_n),
		.dac_codes(dac_codes), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
	);
	ods_host_model host_u
	(
		.sys_clk(sys_clk), .frame_sync_n(frame_sync_n), .serial_clock_in(serial_clock_in),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out)
	);
	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("Counts: %0d mismatches in %0d checks", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
		begin
			if (++n > 20)
			begin
				mismatches++;
				results();
			end
			@(posedge sys_clk);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic sc_chan;
		for (int c = 0; c < 8; c++)
			host_u.send({12'h05a0 + c[11:0], 1'b0, c[2:0]}, 0);
		for (int c = 0; c < 8; c++)
		begin
			bus(0, REG_IN_BASE + 8'(4 * c), 0);
			chk(rd, 12'h05a0 + c);
		end
		load_all_n <= 1'b0;
		wt(6);
		load_all_n <= 1'b1;
		wt(6);
		for (int c = 0; c < 8; c++)
			chk(dac_codes[12*c+:12], 12'h05a0 + c);
		bus(0, REG_OUT_BASE, 0);
		chk(rd, 12'h05a0);
	endtask
	task automatic sc_miss;
		host_u.send(16'hf3f8, 4);
		bus(0, REG_IN_BASE, 0);
		chk(rd, 12'h05a0);
		host_u.send(16'h1230, 0);
		chk(host_u.echo_q, 16'hf3f8);
		bus(0, REG_IN_BASE, 0);
		chk(rd, 12'h0123);
	endtask
	task automatic sc_clr;
		clear_outputs_n <= 1'b0;
		wt(6);
		chk(dac_codes, 96'h0);
		load_all_n <= 1'b0;
		wt(6);
		chk(dac_codes, 96'h0);
		bus(0, REG_IN_BASE + 8'h04, 0);
		chk(rd, 12'h05a1);
		clear_outputs_n <= 1'b1;
		wt(6);
		chk(dac_codes[23:0], 24'h5a1_123);
		load_all_n <= 1'b1;
	endtask
	task automatic sc_fifo;
		bus(1, REG_CTRL, 1);
		for (int i = 0; i < 10; i++)
			host_u.send({12'h0100 + i[11:0], 1'b0, i[2:0]}, 0);
		bus(0, REG_STATUS, 0);
		chk(rd, 32'h0000_0086);
		bus(1, REG_STATUS, 2);
		bus(1, REG_CTRL, 0);
		wt(20);
		bus(0, REG_STATUS, 0);
		chk(rd, 0);
		bus(0, REG_IN_BASE, 0);
		chk(rd, 12'h0108);
		bus(0, REG_IN_BASE + 8'h04, 0);
		chk(rd, 12'h0101);
		bus(0, 8'h10, 0);
		chk(rd, 0);
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		reset_n = 1'b0;
		device_address_pin = 1'b0;
		load_all_n = 1'b1;
		clear_outputs_n = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0000_0000;
		mismatches = 0;
		checks = 0;
		wt(5);
		reset_n <= 1'b1;
		wt(4);
		bus(0, REG_IN_BASE, 0);
		chk(rd, CODE_RESET);
		sc_chan();
		sc_miss();
		sc_clr();
		sc_fifo();
		results();
	end
endmodule
